// File: verilog/cae_regs.svh
/*
 * Offsets, widths and timing counts for the ALU and flow execution block.
 * Assumes nothing; definitions only.
 */
`ifndef CAE_REGS_SVH
`define CAE_REGS_SVH
`define CAE_CYC_ONE 3'h1
`define CAE_CYC_TWO 3'h2
`define CAE_CYC_THREE 3'h3
`define CAE_CYC_FOUR 3'h4
`define CAE_ALL_ONES 8'hff
`define CAE_ALL_ZERO 8'h00
`define CAE_FLAG_C 0
`define CAE_FLAG_Z 1
`define CAE_FLAG_N 2
`define CAE_FLAG_V 3
`define CAE_FLAG_S 4
`define CAE_FLAG_H 5
`define CAE_PC_RESET 16'h0000
`define CAE_SP_RESET 16'h04ff
`endif

// File: verilog/cae_pkg.sv
/*
 * Types for the ALU and flow execution block.
 * Assumes cae_regs.svh for numeric constants.
 */
package cae_pkg;
    typedef enum logic [5:0] {
        OP_ADD, OP_ADD_CARRY, OP_WORD_IMM_ADD, OP_SUB, OP_SUB_IMM, OP_SUB_BORROW,
        OP_SUB_BORROW_IMM, OP_WORD_IMM_SUB, OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM,
        OP_XOR_REGS, OP_BITWISE_INVERT, OP_ZERO_MINUS_REG, OP_BIT_SET_MASK,
        OP_BIT_CLEAR_MASK, OP_PLUS_ONE, OP_MINUS_ONE, OP_SELF_AND_TEST, OP_ZEROING_REG,
        OP_ALL_ONES_LOAD, OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
        OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
        OP_FRACTION_PRODUCT_MIXED, OP_RELATIVE_BRANCH, OP_POINTER_BRANCH,
        OP_ABSOLUTE_BRANCH, OP_RELATIVE_SUBROUTINE_ENTRY,
        OP_POINTER_SUBROUTINE_ENTRY, OP_ABSOLUTE_SUBROUTINE_ENTRY, OP_SUBROUTINE_EXIT
    } cae_op_e;

    typedef struct packed {
        cae_op_e op;
        logic [4:0] rd;
        logic [4:0] rr;
        logic [7:0] imm;
        logic [15:0] addr;
        logic [1:0] words;
    } cae_cmd_s;

    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } cae_flags_s;
endpackage

// File: verilog/cae_mult.sv
/*
 * 8x8 multiplier with signed/unsigned operand selection and fractional shift.
 * Assumes operands are held stable while it is read; purely combinational.
 */
`timescale 1ns/1ps
module cae_mult
    import cae_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic a_signed,
    input wire logic b_signed,
    input wire logic fraction,
    output logic [15:0] product,
    output logic carry
);
    logic signed [17:0] full;
    logic [15:0] raw;

    always_comb begin
        full = $signed({a_signed & a[7], a_signed & a[7], a})
             * $signed({b_signed & b[7], b_signed & b[7], b});
        raw = full[15:0];
        // carry is bit 15 before the fractional shift drops it
        carry = raw[15];
        product = fraction ? {raw[14:0], 1'b0} : raw;
    end
endmodule

// File: verilog/cae_core.sv
/*
 * Execution unit: register file, flags, arithmetic, multiply and flow control.
 * Assumes a decoder presents one command with cmd_valid and waits for cmd_ready.
 */
`timescale 1ns/1ps
`include "cae_regs.svh"
module cae_core
    import cae_pkg::*;
#(
    parameter int STACK_DEPTH = 64
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire cae_cmd_s cmd,
    output logic [15:0] pc,
    output cae_flags_s flags,
    input wire logic [4:0] peek_addr,
    output logic [7:0] peek_data,
    output logic done
);
    localparam int SW = $clog2(STACK_DEPTH);

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY} cae_state_e;

    logic [7:0] regs_q [32];
    logic [7:0] regs_d [32];
    logic [15:0] stack_q [STACK_DEPTH];
    logic [15:0] stack_d [STACK_DEPTH];
    logic [SW-1:0] sp_q, sp_d;
    logic [15:0] pc_q, pc_d;
    cae_flags_s flags_q, flags_d;
    cae_state_e state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [15:0] pend_pc_q, pend_pc_d;
    logic pend_wr_q, pend_wr_d;
    logic [15:0] pend_val_q, pend_val_d;
    logic [4:0] pend_reg_q, pend_reg_d;
    logic done_q, done_d;
    logic [7:0] peek_q;

    logic [7:0] a, b, res;
    logic [8:0] sum9;
    logic [16:0] w17;
    logic [15:0] wa, wres, nxt;
    logic [2:0] cyc;
    logic [15:0] mprod;
    logic mcarry, m_as, m_bs, m_fr;
    logic [7:0] sub_x, sub_y;

    assign a = regs_q[cmd.rd];
    assign b = regs_q[cmd.rr];
    assign wa = {regs_q[cmd.rd + 5'h01], regs_q[cmd.rd]};
    assign nxt = pc_q + {14'h0000, cmd.words};

    always_comb begin
        m_as = cmd.op inside {OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
                              OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED};
        m_bs = cmd.op inside {OP_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_SIGNED};
        m_fr = cmd.op inside {OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
                              OP_FRACTION_PRODUCT_MIXED};
    end

    cae_mult u_cae_mult (
        .a(a),
        .b(b),
        .a_signed(m_as),
        .b_signed(m_bs),
        .fraction(m_fr),
        .product(mprod),
        .carry(mcarry)
    );

    assign cmd_ready = (state_q == ST_IDLE);
    assign pc = pc_q;
    assign flags = flags_q;
    assign peek_data = peek_q;
    assign done = done_q;

    always_comb begin
        regs_d = regs_q;
        stack_d = stack_q;
        sp_d = sp_q;
        pc_d = pc_q;
        flags_d = flags_q;
        state_d = state_q;
        cnt_d = cnt_q;
        pend_pc_d = pend_pc_q;
        pend_wr_d = pend_wr_q;
        pend_val_d = pend_val_q;
        pend_reg_d = pend_reg_q;
        done_d = 1'b0;
        res = 8'h00;
        sum9 = 9'h000;
        w17 = 17'h00000;
        wres = 16'h0000;
        cyc = `CAE_CYC_ONE;
        sub_x = 8'h00;
        sub_y = 8'h00;
        if (state_q == ST_BUSY) begin
            // register and pc results land on the last cycle; flags and the return stack were already updated at issue
            if (cnt_q == `CAE_CYC_ONE) begin
                state_d = ST_IDLE;
                pc_d = pend_pc_q;
                done_d = 1'b1;
                if (pend_wr_q) begin
                    regs_d[pend_reg_q] = pend_val_q[7:0];
                    regs_d[pend_reg_q + 5'h01] = pend_val_q[15:8];
                end
            end else begin
                cnt_d = cnt_q - `CAE_CYC_ONE;
            end
        end else if (cmd_valid) begin
            pend_pc_d = nxt;
            pend_wr_d = 1'b0;
            unique case (cmd.op)
                OP_ADD, OP_ADD_CARRY: begin
                    sum9 = {1'b0, a} + {1'b0, b}
                         + {8'h00, (cmd.op == OP_ADD_CARRY) & flags_q.c};
                    res = sum9[7:0];
                    flags_d.c = sum9[8];
                    flags_d.h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
                    flags_d.v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
                end
                OP_SUB, OP_SUB_IMM, OP_SUB_BORROW, OP_SUB_BORROW_IMM, OP_ZERO_MINUS_REG: begin
                    sub_x = (cmd.op == OP_ZERO_MINUS_REG) ? `CAE_ALL_ZERO : a;
                    sub_y = (cmd.op == OP_ZERO_MINUS_REG) ? a :
                        (cmd.op inside {OP_SUB_IMM, OP_SUB_BORROW_IMM}) ? cmd.imm : b;
                    sum9 = {1'b0, sub_x} - {1'b0, sub_y}
                         - {8'h00, (cmd.op inside {OP_SUB_BORROW, OP_SUB_BORROW_IMM})
                                   & flags_q.c};
                    res = sum9[7:0];
                    flags_d.c = sum9[8];
                    flags_d.h = (~sub_x[3] & sub_y[3]) | (sub_y[3] & res[3])
                              | (res[3] & ~sub_x[3]);
                    flags_d.v = (sub_x[7] & ~sub_y[7] & ~res[7])
                              | (~sub_x[7] & sub_y[7] & res[7]);
                end
                OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR_REGS, OP_BIT_SET_MASK,
                OP_BIT_CLEAR_MASK, OP_SELF_AND_TEST, OP_ZEROING_REG: begin
                    unique case (cmd.op)
                        OP_AND: res = a & b;
                        OP_AND_IMM: res = a & cmd.imm;
                        OP_OR: res = a | b;
                        OP_OR_IMM, OP_BIT_SET_MASK: res = a | cmd.imm;
                        OP_XOR_REGS: res = a ^ b;
                        OP_BIT_CLEAR_MASK: res = a & (`CAE_ALL_ONES - cmd.imm);
                        OP_SELF_AND_TEST: res = a & a;
                        default: res = a ^ a;
                    endcase
                    flags_d.v = 1'b0;
                end
                OP_PLUS_ONE, OP_MINUS_ONE: begin
                    res = (cmd.op == OP_PLUS_ONE) ? a + 8'h01 : a - 8'h01;
                    flags_d.v = (cmd.op == OP_PLUS_ONE) ? (a == 8'h7f) : (a == 8'h80);
                end
                OP_BITWISE_INVERT: begin
                    res = `CAE_ALL_ONES - a;
                    flags_d.c = 1'b1;
                    flags_d.v = 1'b0;
                end
                OP_ALL_ONES_LOAD: res = `CAE_ALL_ONES;
                OP_WORD_IMM_ADD, OP_WORD_IMM_SUB: begin
                    w17 = (cmd.op == OP_WORD_IMM_ADD) ? {1'b0, wa} + {9'h000, cmd.imm}
                                                      : {1'b0, wa} - {9'h000, cmd.imm};
                    wres = w17[15:0];
                    flags_d.c = w17[16];
                    flags_d.v = (cmd.op == OP_WORD_IMM_ADD) ? (~wa[15] & wres[15])
                                                            : (wa[15] & ~wres[15]);
                    flags_d.n = wres[15];
                    flags_d.z = (wres == 16'h0000);
                    pend_wr_d = 1'b1;
                    pend_val_d = wres;
                    pend_reg_d = cmd.rd;
                    cyc = `CAE_CYC_TWO;
                end
                OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
                OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
                OP_FRACTION_PRODUCT_MIXED: begin
                    flags_d.c = mcarry;
                    flags_d.z = (mprod == 16'h0000);
                    pend_wr_d = 1'b1;
                    pend_val_d = mprod;
                    pend_reg_d = 5'h00;
                    cyc = `CAE_CYC_TWO;
                end
                OP_RELATIVE_BRANCH, OP_RELATIVE_SUBROUTINE_ENTRY: begin
                    pend_pc_d = pc_q + cmd.addr + 16'h0001;
                    cyc = (cmd.op == OP_RELATIVE_BRANCH) ? `CAE_CYC_TWO : `CAE_CYC_THREE;
                end
                OP_POINTER_BRANCH, OP_POINTER_SUBROUTINE_ENTRY: begin
                    pend_pc_d = {regs_q[31], regs_q[30]};
                    cyc = (cmd.op == OP_POINTER_BRANCH) ? `CAE_CYC_TWO : `CAE_CYC_THREE;
                end
                OP_ABSOLUTE_BRANCH, OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
                    pend_pc_d = cmd.addr;
                    cyc = (cmd.op == OP_ABSOLUTE_BRANCH) ? `CAE_CYC_THREE : `CAE_CYC_FOUR;
                end
                OP_SUBROUTINE_EXIT: begin
                    sp_d = sp_q - SW'(1);
                    pend_pc_d = stack_q[sp_d];
                    cyc = `CAE_CYC_FOUR;
                end
                default: begin
                end
            endcase
            if (cmd.op inside {OP_RELATIVE_SUBROUTINE_ENTRY, OP_POINTER_SUBROUTINE_ENTRY,
                               OP_ABSOLUTE_SUBROUTINE_ENTRY}) begin
                // overflow wraps silently; depth is the caller's budget
                stack_d[sp_q] = nxt;
                sp_d = sp_q + SW'(1);
            end
            if (cyc == `CAE_CYC_ONE) begin
                pc_d = nxt;
                done_d = 1'b1;
                regs_d[cmd.rd] = res;
                if (cmd.op != OP_ALL_ONES_LOAD) begin
                    flags_d.z = (res == 8'h00);
                    flags_d.n = res[7];
                end
            end else begin
                state_d = ST_BUSY;
                cnt_d = cyc - `CAE_CYC_ONE;
            end
            if (cmd.op inside {OP_WORD_IMM_ADD, OP_WORD_IMM_SUB} || cyc == `CAE_CYC_ONE)
                if (cmd.op != OP_ALL_ONES_LOAD)
                    flags_d.s = flags_d.n ^ flags_d.v;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < 32; i++) begin
                regs_q[i] <= 8'h00;
            end
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= 16'h0000;
            end
            sp_q <= '0;
            pc_q <= `CAE_PC_RESET;
            flags_q <= '0;
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
            pend_pc_q <= 16'h0000;
            pend_wr_q <= 1'b0;
            pend_val_q <= 16'h0000;
            pend_reg_q <= 5'h00;
            done_q <= 1'b0;
            peek_q <= 8'h00;
        end else begin
            regs_q <= regs_d;
            stack_q <= stack_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            flags_q <= flags_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            pend_pc_q <= pend_pc_d;
            pend_wr_q <= pend_wr_d;
            pend_val_q <= pend_val_d;
            pend_reg_q <= pend_reg_d;
            done_q <= done_d;
            peek_q <= regs_d[peek_addr];
        end
    end
endmodule

// File: dv/cae_core_assertions.sv
/*
 * Concurrent checks on the execution unit's ports: retire timing per class,
 * flags held by flow ops. Assumes the cae_core port list and one clock.
 */
`timescale 1ns/1ps
module cae_core_chk
    import cae_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire cae_cmd_s cmd,
    input wire logic [15:0] pc,
    input wire cae_flags_s flags,
    input wire logic [4:0] peek_addr,
    input wire logic [7:0] peek_data,
    input wire logic done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic tk;
    logic prod_c;
    logic two_c;
    logic three_c;
    logic four_c;
    logic [3:0] hsvn;
    assign tk = cmd_valid && cmd_ready;
    assign prod_c = cmd.op >= OP_PRODUCT_UNSIGNED && cmd.op <= OP_FRACTION_PRODUCT_MIXED;
    assign two_c = prod_c || cmd.op inside {OP_WORD_IMM_ADD, OP_WORD_IMM_SUB,
        OP_RELATIVE_BRANCH, OP_POINTER_BRANCH};
    assign three_c = cmd.op inside {OP_ABSOLUTE_BRANCH, OP_RELATIVE_SUBROUTINE_ENTRY,
        OP_POINTER_SUBROUTINE_ENTRY};
    assign four_c = cmd.op inside {OP_ABSOLUTE_SUBROUTINE_ENTRY, OP_SUBROUTINE_EXIT};
    // flags that a product must leave alone
    assign hsvn = {flags.h, flags.s, flags.v, flags.n};
    AST_ONE_CYC: assert property (
        tk && !(two_c || three_c || four_c) |=> done && cmd_ready)
        else $error("single-cycle op did not retire next cycle");
    AST_TWO_CYC: assert property (
        tk && two_c |=> !done && !cmd_ready ##1 done)
        else $error("two-cycle op retired at wrong time");
    AST_THREE_CYC: assert property (
        tk && three_c |=> (!done && !cmd_ready) [*2] ##1 done)
        else $error("three-cycle op retired at wrong time");
    AST_FOUR_CYC: assert property (tk && four_c |=> (!done && !cmd_ready) [*3] ##1 done)
        else $error("four-cycle op retired at wrong time");
    AST_FLOW_FLAGS: assert property (
        tk && cmd.op >= OP_RELATIVE_BRANCH |=> $stable(flags) [*2])
        else $error("flow op changed flags");
    AST_SET_FLAGS: assert property (tk && cmd.op == OP_ALL_ONES_LOAD |=> $stable(flags))
        else $error("all-ones load changed flags");
    AST_PROD_ONLY_ZC: assert property (tk && prod_c |=> $stable(hsvn))
        else $error("multiply touched other flags");
    AST_CARRY_KEPT: assert property (
        tk && cmd.op inside {OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR_REGS,
        OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK, OP_PLUS_ONE, OP_MINUS_ONE, OP_SELF_AND_TEST,
        OP_ZEROING_REG} |=> $stable(flags.c))
        else $error("logic op changed carry");
    AST_WORD_SIGN: assert property (
        tk && cmd.op inside {OP_WORD_IMM_ADD, OP_WORD_IMM_SUB}
        |=> ##1 flags.s == (flags.n ^ flags.v)) else $error("sign flag not n xor v");
    AST_PC_AT_RETIRE: assert property ($changed(pc) |-> done)
        else $error("pc moved without retire");
    cover property (tk && four_c);
    cover property (tk && cmd.op == OP_FRACTION_PRODUCT_SIGNED);
    cover property (tk && cmd.op == OP_SUBROUTINE_EXIT);
endmodule
bind cae_core cae_core_chk u_cae_core_chk (.clock(clock), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .pc(pc), .flags(flags),
    .peek_addr(peek_addr), .peek_data(peek_data), .done(done));

// File: dv/cae_core_tb_top.sv
/*
 * Self-checking bench for the execution unit: arithmetic, logic, multiply
 * and flow. Assumes registers start at zero; R31:R30 is set to 0x00ff.
 */
`timescale 1ns/1ps
module cae_core_tb_top
    import cae_pkg::*;
;
    logic clock;
    logic reset_n;
    logic cmd_valid;
    logic cmd_ready;
    cae_cmd_s cmd;
    logic [15:0] pc;
    cae_flags_s flags;
    logic [4:0] peek_addr;
    logic [7:0] peek_data;
    logic done;
    int n_mismatch = 0;
    int compares = 0;
    logic [15:0] epc = 16'h0000;
    logic [15:0] stk[$];
    cae_core u_cae_core (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd(cmd), .pc(pc), .flags(flags),
        .peek_addr(peek_addr), .peek_data(peek_data), .done(done));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic fl(logic [5:0] e);
        chk("flags", {10'h000, flags}, {10'h000, e});
    endtask
    task automatic pk(logic [4:0] a, logic [7:0] e);
        @(posedge clock);
        peek_addr <= a;
        @(posedge clock);
        #1;
        chk("reg", {8'h00, peek_data}, {8'h00, e});
    endtask
    // issue one op from idle, count cycles to retire, track pc and return stack
    task automatic ex(cae_op_e op, logic [4:0] d, logic [4:0] r = 5'h00,
        logic [7:0] k = 8'h00, logic [15:0] a = 16'h0000, logic [1:0] w = 2'h1);
        int n;
        int c;
        logic [15:0] nx;
        n = 1;
        if (op inside {OP_WORD_IMM_ADD, OP_WORD_IMM_SUB, OP_RELATIVE_BRANCH, OP_POINTER_BRANCH}
            || (op >= OP_PRODUCT_UNSIGNED && op <= OP_FRACTION_PRODUCT_MIXED)) n = 2;
        if (op inside {OP_ABSOLUTE_BRANCH, OP_RELATIVE_SUBROUTINE_ENTRY,
            OP_POINTER_SUBROUTINE_ENTRY}) n = 3;
        if (op inside {OP_ABSOLUTE_SUBROUTINE_ENTRY, OP_SUBROUTINE_EXIT}) n = 4;
        nx = epc + 16'(w);
        if (op inside {OP_RELATIVE_SUBROUTINE_ENTRY, OP_POINTER_SUBROUTINE_ENTRY,
            OP_ABSOLUTE_SUBROUTINE_ENTRY}) stk.push_back(nx);
        if (op inside {OP_RELATIVE_BRANCH, OP_RELATIVE_SUBROUTINE_ENTRY}) nx = nx + a;
        // pointer ops are only issued once R31:R30 holds 0x00ff
        if (op inside {OP_POINTER_BRANCH, OP_POINTER_SUBROUTINE_ENTRY}) nx = 16'h00ff;
        if (op inside {OP_ABSOLUTE_BRANCH, OP_ABSOLUTE_SUBROUTINE_ENTRY}) nx = a;
        if (op == OP_SUBROUTINE_EXIT) nx = stk.pop_back();
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= '{op, d, r, k, a, w};
        @(posedge clock);
        cmd_valid <= 1'b0;
        c = 1;
        #1;
        while (done !== 1'b1 && c < 9) begin
            @(posedge clock);
            #1;
            c++;
        end
        chk("cycles", 16'(c), 16'(n));
        chk("pc", pc, nx);
        epc = nx;
    endtask
    task automatic t_add;
        ex(OP_ALL_ONES_LOAD, 5'h10);
        fl(6'h00);
        pk(5'h10, 8'hff);
        ex(OP_PLUS_ONE, 5'h11);
        ex(OP_ADD, 5'h10, 5'h11);
        pk(5'h10, 8'h00);
        fl(6'h23);
        ex(OP_ADD_CARRY, 5'h11, 5'h11);
        pk(5'h11, 8'h03);
        fl(6'h00);
        $display("test add finished");
    endtask
    task automatic t_sub;
        ex(OP_SUB, 5'h10, 5'h11);
        pk(5'h10, 8'hfd);
        fl(6'h35);
        ex(OP_SUB_BORROW_IMM, 5'h10, 5'h00, 8'h0c);
        pk(5'h10, 8'hf0);
        fl(6'h14);
        ex(OP_SUB_IMM, 5'h14, 5'h00, 8'h01);
        fl(6'h35);
        ex(OP_SUB_BORROW, 5'h14, 5'h11);
        pk(5'h14, 8'hfb);
        fl(6'h14);
        $display("test sub finished");
    endtask
    task automatic t_word;
        ex(OP_WORD_IMM_SUB, 5'h18, 5'h00, 8'h01);
        pk(5'h18, 8'hff);
        pk(5'h19, 8'hff);
        fl(6'h15);
        ex(OP_WORD_IMM_ADD, 5'h18, 5'h00, 8'h01);
        pk(5'h19, 8'h00);
        fl(6'h03);
        $display("test word finished");
    endtask
    task automatic t_logic;
        cae_op_e ops[11] = '{OP_OR_IMM, OP_BIT_CLEAR_MASK, OP_BIT_SET_MASK, OP_AND_IMM,
            OP_BITWISE_INVERT, OP_ZERO_MINUS_REG, OP_XOR_REGS, OP_MINUS_ONE,
            OP_SELF_AND_TEST, OP_AND, OP_OR};
        logic [4:0] rs[11] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h12, 5'h00,
            5'h00, 5'h11, 5'h10};
        logic [7:0] ks[11] = '{8'ha5, 8'h0f, 8'h01, 8'h3c, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00};
        logic [7:0] vs[11] = '{8'ha5, 8'ha0, 8'ha1, 8'h20, 8'hdf, 8'h21, 8'h00, 8'hff,
            8'hff, 8'h03, 8'hf3};
        for (int i = 0; i < 11; i++) begin
            ex(ops[i], 5'h12, rs[i], ks[i]);
            pk(5'h12, vs[i]);
            if (i == 4) fl(6'h15);
            if (i == 5) fl(6'h21);
        end
        fl(6'h35);
        ex(OP_ZEROING_REG, 5'h12);
        pk(5'h12, 8'h00);
        fl(6'h23);
        $display("test logic finished");
    endtask
    task automatic t_mult;
        cae_op_e ops[7] = '{OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_MIXED,
            OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
            OP_FRACTION_PRODUCT_MIXED, OP_PRODUCT_UNSIGNED};
        logic [4:0] rr[7] = '{5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h11, 5'h13};
        logic [15:0] p[7] = '{16'h02d0, 16'hffd0, 16'hffd0, 16'h05a0, 16'hffa0, 16'hffa0,
            16'h0000};
        logic [5:0] cz[7] = '{6'h00, 6'h01, 6'h01, 6'h00, 6'h01, 6'h01, 6'h02};
        for (int i = 0; i < 7; i++) begin
            ex(ops[i], 5'h10, rr[i]);
            pk(5'h00, p[i][7:0]);
            pk(5'h01, p[i][15:8]);
            fl(6'h20 | cz[i]);
        end
        $display("test multiply finished");
    endtask
    task automatic t_flow;
        logic [5:0] sf;
        sf = flags;
        ex(OP_RELATIVE_SUBROUTINE_ENTRY, 5'h00, 5'h00, 8'h00, 16'h0010);
        ex(OP_ALL_ONES_LOAD, 5'h1e);
        pk(5'h1e, 8'hff);
        ex(OP_POINTER_SUBROUTINE_ENTRY, 5'h00);
        ex(OP_ABSOLUTE_SUBROUTINE_ENTRY, 5'h00, 5'h00, 8'h00, 16'h1234, 2'h2);
        repeat (3) ex(OP_SUBROUTINE_EXIT, 5'h00);
        ex(OP_RELATIVE_BRANCH, 5'h00, 5'h00, 8'h00, 16'hfffe);
        ex(OP_POINTER_BRANCH, 5'h00);
        ex(OP_ABSOLUTE_BRANCH, 5'h00, 5'h00, 8'h00, 16'h0300, 2'h2);
        fl(sf);
        $display("test flow finished");
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        peek_addr = 5'h00;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        #1;
        chk("ready", {15'h0000, cmd_ready}, 16'h0001);
        fl(6'h00);
        t_add;
        t_sub;
        t_word;
        t_logic;
        t_mult;
        t_flow;
        complete_run;
    end
    // whole run needs well under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        complete_run;
    end
endmodule
